/* rtl/srce_map.svh */
/*
  Constants of the serial register command engine: opcodes, reply bytes,
  error codes, command addresses, baud rates and timing figures.
  Assumes inclusion by bare name from the design and bench files.
*/
`ifndef SRCE_MAP_SVH
`define SRCE_MAP_SVH

`define SRCE_OP_WRITE 8'h57
`define SRCE_OP_READ 8'h52
`define SRCE_ACK 8'h06
`define SRCE_NAK 8'h15

`define SRCE_ERR_NONE 8'h00
`define SRCE_ERR_INVALID 8'h01
`define SRCE_ERR_TIMEOUT 8'h02
`define SRCE_ERR_CHECKSUM 8'h03
`define SRCE_ERR_MIN 8'h04
`define SRCE_ERR_MAX 8'h05
`define SRCE_ERR_RSVD 8'h06
`define SRCE_ERR_SUPER 8'h07
`define SRCE_ERR_MODE 8'h08

`define SRCE_ADDR_BOOT_SEL 16'h6000
`define SRCE_ADDR_RESTART 16'h601C
`define SRCE_ADDR_LOAD_FAC 16'h6060
`define SRCE_ADDR_LOAD_U1 16'h6064
`define SRCE_ADDR_LOAD_U2 16'h6068
`define SRCE_ADDR_SAVE_U1 16'h6074
`define SRCE_ADDR_SAVE_U2 16'h6078
`define SRCE_RESTART_KEY 32'hDEADBEEF
`define SRCE_BOOT_SEL_RESET 2'h0

`define SRCE_BAUD_9600 32'h00002580
`define SRCE_BAUD_19200 32'h00004B00
`define SRCE_BAUD_38400 32'h00009600
`define SRCE_BAUD_57600 32'h0000E100
`define SRCE_BAUD_115200 32'h0001C200
`define SRCE_BAUD_SEL_DEFAULT 3'h4

`define SRCE_CLK_HZ 32'h02FAF080
`define SRCE_HZ_PER_MHZ 32'h000F4240
`define SRCE_TIMEOUT_US 32'h00002710

`endif

/* rtl/srce_pkg.sv */
/*
  Types of the serial register command engine: control states, space codes
  and the copy descriptor. Assumes nothing of its surroundings.
*/
package srce_pkg;

  typedef enum logic [3:0] {
    ST_BOOT  = 4'b0001,
    ST_CMD   = 4'b0010,
    ST_COPY  = 4'b0100,
    ST_REPLY = 4'b1000
  } srce_state_t;

  typedef enum logic [1:0] {
    SP_FACTORY = 2'h0,
    SP_USER1   = 2'h1,
    SP_USER2   = 2'h2,
    SP_WORK    = 2'h3
  } srce_space_t;

  typedef struct packed {
    srce_space_t src;
    srce_space_t dst;
  } srce_copy_t;

endpackage

/* rtl/srce_top.sv */
/*
  Serial register command engine: uart receiver and transmitter, frame
  parser, workspace, factory space and two user spaces with load, save,
  boot select and keyed restart.
  Assumes rx_i is an asynchronous pin, baud_sel_i comes from logic on clk_i,
  and reset_i is the power-on reset.
*/
`timescale 1ns/1ps
`include "srce_map.svh"

// Summary of operation
// - 8N1 characters, no parity, no handshake
// - selectable baud, 115200 by default
// - 16-bit address, 32-bit data per transaction
// - narrow registers packed low, upper bits zero
// - good write answered with 0x06
// - failed write answered 0x15 plus code
// - good read: ack then four bytes MSB first
// - reads never nak except bad opcode or timeout
// - unknown read address returns ack, zeros
// - bad opcode rejected with code 01
// - error code encoding 00 to 08
// - boot selector at 0x6000, two bits
// - boot load completes before commands accepted
// - load triggers replace whole workspace
// - save triggers copy workspace to user
// - keyed restart reloads per boot selector
// - factory space never written
// - workspace volatile, user spaces retained
module srce_top #(
  parameter int unsigned CLK_HZ = `SRCE_CLK_HZ,
  parameter int unsigned WS_DEPTH = 64,
  parameter int unsigned TIMEOUT_CYC = `SRCE_TIMEOUT_US * (CLK_HZ / `SRCE_HZ_PER_MHZ),
  parameter logic [31:0] FACTORY_FILL = 32'h00000000,
  parameter int unsigned IDX_W = $clog2(WS_DEPTH)
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic rx_i,
  output logic tx_o,
  input wire logic [2:0] baud_sel_i,
  output logic ready_o,
  input wire logic [IDX_W-1:0] ws_index_i,
  output logic [31:0] ws_data_o
);

  srce_pkg::srce_state_t state_ff;
  srce_pkg::srce_copy_t copy_ff;
  logic [2:0] rx_sync_ff;
  logic rx_line_ff;
  logic [15:0] div_ff;
  logic rx_busy_ff;
  logic [15:0] rx_cnt_ff;
  logic [3:0] rx_bit_ff;
  logic [7:0] rx_shift_ff;
  logic rx_valid_ff;
  logic tx_busy_ff;
  logic [15:0] tx_cnt_ff;
  logic [3:0] tx_bit_ff;
  logic [8:0] tx_shift_ff;
  logic tx_line_ff;
  logic [7:0] op_ff;
  logic [39:0] frame_ff;
  logic [2:0] bcnt_ff;
  logic [31:0] idle_cnt_ff;
  logic [39:0] reply_ff;
  logic [2:0] reply_len_ff;
  logic [IDX_W-1:0] idx_ff;
  logic [1:0] boot_sel_ff;
  logic [31:0] ws_ff [WS_DEPTH];
  logic [31:0] u1_ff [WS_DEPTH];
  logic [31:0] u2_ff [WS_DEPTH];
  logic tx_start;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  logic [15:0] rd_addr;
  logic frame_done_w;
  logic frame_done_r;
  logic copy_last;
  logic [31:0] copy_word;

  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    case (sel)
      3'h0: baud_div = 16'(CLK_HZ / `SRCE_BAUD_9600);
      3'h1: baud_div = 16'(CLK_HZ / `SRCE_BAUD_19200);
      3'h2: baud_div = 16'(CLK_HZ / `SRCE_BAUD_38400);
      3'h3: baud_div = 16'(CLK_HZ / `SRCE_BAUD_57600);
      default: baud_div = 16'(CLK_HZ / `SRCE_BAUD_115200);
    endcase
  endfunction

  function automatic logic in_ws(input logic [15:0] a);
    in_ws = (a[1:0] == 2'h0) && ({16'h0000, a} < 32'(WS_DEPTH * 4));
  endfunction

  // reserved selector code falls back to the factory space
  function automatic srce_pkg::srce_space_t boot_space(input logic [1:0] sel);
    boot_space = (sel == 2'h3) ? srce_pkg::SP_FACTORY : srce_pkg::srce_space_t'(sel);
  endfunction

  // first stage feeds only the second
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_sync_ff <= 3'h7;
      rx_line_ff <= 1'b1;
    end else begin
      rx_sync_ff <= {rx_sync_ff[1:0], rx_i};
      if (rx_sync_ff[1] == rx_sync_ff[2]) begin
        rx_line_ff <= rx_sync_ff[2];
      end
    end
  end

  // rate changes only between characters so no byte is torn
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_ff <= baud_div(`SRCE_BAUD_SEL_DEFAULT);
    end else if (!rx_busy_ff && !tx_busy_ff) begin
      div_ff <= baud_div(baud_sel_i);
    end
  end

  // receiver: mid-bit sampling, stop bit must be high
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_busy_ff <= 1'b0;
      rx_cnt_ff <= 16'h0000;
      rx_bit_ff <= 4'h0;
      rx_shift_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      if (!rx_busy_ff) begin
        if (!rx_line_ff) begin
          rx_busy_ff <= 1'b1;
          rx_cnt_ff <= {1'b0, div_ff[15:1]};
          rx_bit_ff <= 4'h0;
        end
      end else if (rx_cnt_ff != 16'h0000) begin
        rx_cnt_ff <= rx_cnt_ff - 16'h0001;
      end else begin
        rx_cnt_ff <= div_ff - 16'h0001;
        rx_bit_ff <= rx_bit_ff + 4'h1;
        if (rx_bit_ff == 4'h0) begin
          if (rx_line_ff) begin
            rx_busy_ff <= 1'b0;
          end
        end else if (rx_bit_ff <= 4'h8) begin
          rx_shift_ff <= {rx_line_ff, rx_shift_ff[7:1]};
        end else begin
          rx_busy_ff <= 1'b0;
          rx_valid_ff <= rx_line_ff;
        end
      end
    end
  end

  assign tx_start = (state_ff == srce_pkg::ST_REPLY) && !tx_busy_ff && (reply_len_ff != 3'h0);

  // transmitter: start, eight data lsb first, one stop
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_busy_ff <= 1'b0;
      tx_cnt_ff <= 16'h0000;
      tx_bit_ff <= 4'h0;
      tx_shift_ff <= 9'h1FF;
      tx_line_ff <= 1'b1;
    end else if (tx_start) begin
      tx_busy_ff <= 1'b1;
      tx_cnt_ff <= div_ff - 16'h0001;
      tx_bit_ff <= 4'h0;
      tx_shift_ff <= {1'b1, reply_ff[39:32]};
      tx_line_ff <= 1'b0;
    end else if (tx_busy_ff) begin
      if (tx_cnt_ff != 16'h0000) begin
        tx_cnt_ff <= tx_cnt_ff - 16'h0001;
      end else begin
        tx_cnt_ff <= div_ff - 16'h0001;
        if (tx_bit_ff == 4'h9) begin
          tx_busy_ff <= 1'b0;
        end else begin
          tx_line_ff <= tx_shift_ff[0];
          tx_shift_ff <= {1'b1, tx_shift_ff[8:1]};
          tx_bit_ff <= tx_bit_ff + 4'h1;
        end
      end
    end
  end

  assign wr_addr = frame_ff[39:24];
  assign wr_data = {frame_ff[23:0], rx_shift_ff};
  assign rd_addr = {frame_ff[7:0], rx_shift_ff};
  assign frame_done_w = rx_valid_ff && (bcnt_ff == 3'h6) && (op_ff == `SRCE_OP_WRITE);
  assign frame_done_r = rx_valid_ff && (bcnt_ff == 3'h2) && (op_ff == `SRCE_OP_READ);
  assign copy_last = (idx_ff == IDX_W'(WS_DEPTH - 1));

  always_comb begin
    case (copy_ff.src)
      srce_pkg::SP_FACTORY: copy_word = FACTORY_FILL + 32'(idx_ff);
      srce_pkg::SP_USER1: copy_word = u1_ff[idx_ff];
      srce_pkg::SP_USER2: copy_word = u2_ff[idx_ff];
      default: copy_word = ws_ff[idx_ff];
    endcase
  end

  // read map: workspace words, boot selector, zeros elsewhere
  function automatic logic [31:0] rd_word(input logic [15:0] a);
    if (in_ws(a)) begin
      rd_word = ws_ff[a[IDX_W+1:2]];
    end else if (a == `SRCE_ADDR_BOOT_SEL) begin
      rd_word = {30'h00000000, boot_sel_ff};
    end else begin
      rd_word = 32'h00000000;
    end
  endfunction

  // control: frame parsing, replies and copy sequencing
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= srce_pkg::ST_BOOT;
      copy_ff <= '{src: srce_pkg::SP_FACTORY, dst: srce_pkg::SP_WORK};
      op_ff <= 8'h00;
      frame_ff <= 40'h0000000000;
      bcnt_ff <= 3'h0;
      idle_cnt_ff <= 32'h00000000;
      reply_ff <= 40'h0000000000;
      reply_len_ff <= 3'h0;
      idx_ff <= '0;
    end else begin
      case (state_ff)
        srce_pkg::ST_BOOT: begin
          copy_ff <= '{src: boot_space(boot_sel_ff), dst: srce_pkg::SP_WORK};
          idx_ff <= '0;
          reply_len_ff <= 3'h0;
          state_ff <= srce_pkg::ST_COPY;
        end
        srce_pkg::ST_CMD: begin
          if (rx_valid_ff) begin
            idle_cnt_ff <= 32'h00000000;
            frame_ff <= {frame_ff[31:0], rx_shift_ff};
            bcnt_ff <= bcnt_ff + 3'h1;
            if (bcnt_ff == 3'h0) begin
              op_ff <= rx_shift_ff;
              if (rx_shift_ff != `SRCE_OP_WRITE && rx_shift_ff != `SRCE_OP_READ) begin
                reply_ff <= {`SRCE_NAK, `SRCE_ERR_INVALID, 24'h000000};
                reply_len_ff <= 3'h2;
                bcnt_ff <= 3'h0;
                state_ff <= srce_pkg::ST_REPLY;
              end
            end else if (frame_done_r) begin
              reply_ff <= {`SRCE_ACK, rd_word(rd_addr)};
              reply_len_ff <= 3'h5;
              bcnt_ff <= 3'h0;
              state_ff <= srce_pkg::ST_REPLY;
            end else if (frame_done_w) begin
              reply_ff <= {`SRCE_ACK, 32'h00000000};
              reply_len_ff <= 3'h1;
              bcnt_ff <= 3'h0;
              idx_ff <= '0;
              state_ff <= srce_pkg::ST_REPLY;
              case (wr_addr)
                `SRCE_ADDR_LOAD_FAC: begin
                  copy_ff <= '{src: srce_pkg::SP_FACTORY, dst: srce_pkg::SP_WORK};
                  state_ff <= srce_pkg::ST_COPY;
                end
                `SRCE_ADDR_LOAD_U1: begin
                  copy_ff <= '{src: srce_pkg::SP_USER1, dst: srce_pkg::SP_WORK};
                  state_ff <= srce_pkg::ST_COPY;
                end
                `SRCE_ADDR_LOAD_U2: begin
                  copy_ff <= '{src: srce_pkg::SP_USER2, dst: srce_pkg::SP_WORK};
                  state_ff <= srce_pkg::ST_COPY;
                end
                `SRCE_ADDR_SAVE_U1: begin
                  copy_ff <= '{src: srce_pkg::SP_WORK, dst: srce_pkg::SP_USER1};
                  state_ff <= srce_pkg::ST_COPY;
                end
                `SRCE_ADDR_SAVE_U2: begin
                  copy_ff <= '{src: srce_pkg::SP_WORK, dst: srce_pkg::SP_USER2};
                  state_ff <= srce_pkg::ST_COPY;
                end
                `SRCE_ADDR_RESTART: begin
                  if (wr_data == `SRCE_RESTART_KEY) begin
                    copy_ff <= '{src: boot_space(boot_sel_ff), dst: srce_pkg::SP_WORK};
                    state_ff <= srce_pkg::ST_COPY;
                  end
                end
                default: begin
                end
              endcase
            end
          end else if (bcnt_ff != 3'h0) begin
            idle_cnt_ff <= idle_cnt_ff + 32'h00000001;
            if (idle_cnt_ff >= 32'(TIMEOUT_CYC - 1)) begin
              reply_ff <= {`SRCE_NAK, `SRCE_ERR_TIMEOUT, 24'h000000};
              reply_len_ff <= 3'h2;
              bcnt_ff <= 3'h0;
              idle_cnt_ff <= 32'h00000000;
              state_ff <= srce_pkg::ST_REPLY;
            end
          end
        end
        srce_pkg::ST_COPY: begin
          idx_ff <= idx_ff + IDX_W'(1);
          if (copy_last) begin
            state_ff <= srce_pkg::ST_REPLY;
          end
        end
        srce_pkg::ST_REPLY: begin
          if (tx_start) begin
            reply_ff <= {reply_ff[31:0], 8'h00};
            reply_len_ff <= reply_len_ff - 3'h1;
          end else if (!tx_busy_ff && reply_len_ff == 3'h0) begin
            state_ff <= srce_pkg::ST_CMD;
          end
        end
        default: begin
          state_ff <= srce_pkg::ST_BOOT;
        end
      endcase
    end
  end

  // boot selector models its non-volatile cell; only power-on resets it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      boot_sel_ff <= `SRCE_BOOT_SEL_RESET;
    end else if (state_ff == srce_pkg::ST_CMD && frame_done_w && wr_addr == `SRCE_ADDR_BOOT_SEL) begin
      boot_sel_ff <= wr_data[1:0];
    end
  end

  // factory words are constants, so no write path reaches them
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < WS_DEPTH; i++) begin
        ws_ff[i] <= 32'h00000000;
      end
    end else if (state_ff == srce_pkg::ST_COPY && copy_ff.dst == srce_pkg::SP_WORK) begin
      ws_ff[idx_ff] <= copy_word;
    end else if (state_ff == srce_pkg::ST_CMD && frame_done_w && in_ws(wr_addr)) begin
      ws_ff[wr_addr[IDX_W+1:2]] <= wr_data;
    end
  end

  // user spaces survive keyed restart; power-on stands for a blank cell
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < WS_DEPTH; i++) begin
        u1_ff[i] <= 32'h00000000;
        u2_ff[i] <= 32'h00000000;
      end
    end else if (state_ff == srce_pkg::ST_COPY) begin
      if (copy_ff.dst == srce_pkg::SP_USER1) begin
        u1_ff[idx_ff] <= copy_word;
      end
      if (copy_ff.dst == srce_pkg::SP_USER2) begin
        u2_ff[idx_ff] <= copy_word;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ws_data_o <= 32'h00000000;
    end else begin
      ws_data_o <= ws_ff[ws_index_i];
    end
  end

  assign tx_o = tx_line_ff;
  assign ready_o = (state_ff == srce_pkg::ST_CMD);

endmodule // srce_top

/* bench/srce_top_monitor.sv */
/* Checker for the srce_top ports.
   Assumes a bind to srce_top, one clock, asynchronous active-high reset. */
`timescale 1ns/1ps
module srce_top_monitor #(
  parameter int unsigned IDX_W = 6
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic rx_i,
  input wire logic tx_o,
  input wire logic [2:0] baud_sel_i,
  input wire logic ready_o,
  input wire logic [IDX_W-1:0] ws_index_i,
  input wire logic [31:0] ws_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // longest busy spell is a five-byte reply, so a stuck engine shows here
  logic [11:0] busy_cnt_ff;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt_ff <= 12'h000;
    end else if (ready_o) begin
      busy_cnt_ff <= 12'h000;
    end else begin
      busy_cnt_ff <= busy_cnt_ff + 12'h001;
    end
  end
  boot_hold_a: assert property ($fell(reset_i) |-> !ready_o [*8])
    else $error("ready before boot load");
  boot_done_a: assert property ($fell(reset_i) |-> ##[9:40] ready_o)
    else $error("boot load never ends");
  line_idle_a: assert property (ready_o |-> tx_o)
    else $error("line busy while ready");
  reply_busy_a: assert property ($fell(tx_o) |-> !ready_o)
    else $error("reply while ready");
  reply_start_a: assert property ($fell(ready_o) |-> ##[1:30] !tx_o)
    else $error("no reply after frame");
  start_len_a: assert property ($fell(tx_o) |-> !tx_o [*8])
    else $error("start bit too short");
  mark_len_a: assert property ($rose(tx_o) |-> tx_o [*8])
    else $error("high bit too short");
  busy_bound_a: assert property (busy_cnt_ff < 12'hA00)
    else $error("engine busy too long");
  ws_steady_a: assert property (ready_o && $past(ready_o)
    && ($past(ws_index_i) == $past(ws_index_i, 2)) |-> $stable(ws_data_o))
    else $error("workspace changed while idle");
  cover property ($fell(ready_o));
  cover property ($rose(ready_o));
  cover property ($changed(ws_data_o) && ready_o);
endmodule // srce_top_monitor

/* bench/srce_host.sv */
/* Host side of the serial line: sends and receives 8N1 characters.
   Assumes the testbench calls its tasks and gives the bit time in cycles. */
`timescale 1ns/1ps
module srce_host #(
  parameter int BIT = 43
) (
  input wire logic clk_i,
  input wire logic tx_i,
  output logic rx_o
);
  // bit time in cycles; the bench retunes it when it moves the line rate
  int bit_cyc = BIT;
  initial rx_o = 1'b1;
  // start, eight data bits lsb first, stop; no parity, no handshake
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    rx_o <= 1'b0;
    repeat (bit_cyc) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rx_o <= b[i];
      repeat (bit_cyc) @(posedge clk_i);
    end
    rx_o <= 1'b1;
    repeat (bit_cyc) @(posedge clk_i);
  endtask
  // samples mid-bit; a missing start or stop leaves unknowns
  task automatic recv(output logic [7:0] b);
    int k;
    b = 8'hXX;
    // wait limit scales with the rate so a seven-byte frame fits at any rate
    for (k = 0; k < 120 * bit_cyc && tx_i; k++) @(posedge clk_i);
    if (!tx_i) begin
      repeat (bit_cyc / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge clk_i);
        b[i] = tx_i;
      end
      repeat (bit_cyc) @(posedge clk_i);
      if (!tx_i) b = 8'hXX;
    end
  endtask
endmodule // srce_host

/* bench/testbench.sv */
/* Testbench for srce_top: host frames, replies and workspace readback.
   Assumes srce_host and srce_top_monitor are compiled beforehand. */
`timescale 1ns/1ps
`include "srce_map.svh"
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic rx_i;
  logic tx_o;
  logic ready_o;
  logic [2:0] baud_sel_i = `SRCE_BAUD_SEL_DEFAULT;
  logic [2:0] ws_index_i = 3'h0;
  logic [31:0] ws_data_o;
  int mismatches = 0;
  int check_count = 0;
  localparam int unsigned SIM_HZ = 32'h004C4B40;
  // small clock figure keeps a bit at 43 cycles, default rate
  srce_top #(.CLK_HZ(SIM_HZ), .WS_DEPTH(8), .TIMEOUT_CYC(2000)) dut_u (
    .clk_i(clk_i), .reset_i(reset_i), .rx_i(rx_i), .tx_o(tx_o),
    .baud_sel_i(baud_sel_i), .ready_o(ready_o), .ws_index_i(ws_index_i),
    .ws_data_o(ws_data_o));
  srce_host #(.BIT(43)) host_u (.clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_i));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %0t %s: got %h want %h", $time, m, seen, exp);
    end
  endtask
  task automatic wait_ready();
    for (int k = 0; k < 100 && ready_o !== 1'b1; k++) @(posedge clk_i);
    check({31'h0, ready_o}, 32'h1, "ready back");
  endtask
  task automatic frame(input logic [7:0] s[$], input logic [7:0] e[$], input string m);
    logic [7:0] r[$];
    logic [7:0] b;
    fork
      foreach (s[i]) host_u.send(s[i]);
      repeat (e.size()) begin
        host_u.recv(b);
        r.push_back(b);
      end
    join
    foreach (e[i]) check({24'h0, r[i]}, {24'h0, e[i]}, m);
    wait_ready();
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    frame('{`SRCE_OP_WRITE, a[15:8], a[7:0], d[31:24], d[23:16], d[15:8], d[7:0]},
      '{`SRCE_ACK}, "write ack");
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] d);
    frame('{`SRCE_OP_READ, a[15:8], a[7:0]},
      '{`SRCE_ACK, d[31:24], d[23:16], d[15:8], d[7:0]}, "read data");
  endtask
  task automatic ws(input logic [2:0] i, input logic [31:0] d);
    @(posedge clk_i);
    ws_index_i <= i;
    repeat (2) @(posedge clk_i);
    #1;
    check(ws_data_o, d, "workspace word");
  endtask
  task automatic t_boot();
    wait_ready();
    for (int i = 0; i < 8; i++) ws(i[2:0], i);
  endtask
  task automatic t_map();
    rd(16'h001C, 32'h00000007);
    rd(16'h0020, 32'h00000000);
    rd(16'h7004, 32'h00000000);
  endtask
  task automatic t_rw();
    wr(16'h0004, 32'h11223344);
    rd(16'h0004, 32'h11223344);
    ws(3'h1, 32'h11223344);
  endtask
  task automatic t_badop();
    logic [7:0] ops[$] = '{8'h00, 8'h41, 8'h53, 8'hFF};
    foreach (ops[i]) frame('{ops[i]}, '{`SRCE_NAK, `SRCE_ERR_INVALID}, "bad op");
  endtask
  task automatic t_timeout();
    // stall after two bytes; the part frame must be thrown away
    frame('{`SRCE_OP_WRITE, 8'h00}, '{`SRCE_NAK, `SRCE_ERR_TIMEOUT}, "stall");
    rd(16'h0004, 32'h11223344);
  endtask
  task automatic t_spaces();
    wr(`SRCE_ADDR_SAVE_U1, 32'h00000000);
    wr(16'h0004, 32'hCAFE0001);
    ws(3'h1, 32'hCAFE0001);
    wr(`SRCE_ADDR_LOAD_U1, 32'h12345678);
    ws(3'h1, 32'h11223344);
    wr(`SRCE_ADDR_LOAD_FAC, 32'h00000000);
    ws(3'h1, 32'h00000001);
    wr(`SRCE_ADDR_LOAD_U2, 32'h00000000);
    ws(3'h2, 32'h00000000);
  endtask
  task automatic t_restart();
    wr(`SRCE_ADDR_BOOT_SEL, 32'hFFFFFFFD);
    rd(`SRCE_ADDR_BOOT_SEL, 32'h00000001);
    wr(`SRCE_ADDR_RESTART, 32'hDEADBEEE);
    ws(3'h1, 32'h00000000);
    wr(`SRCE_ADDR_RESTART, `SRCE_RESTART_KEY);
    ws(3'h1, 32'h11223344);
    ws(3'h2, 32'h00000002);
    rd(`SRCE_ADDR_BOOT_SEL, 32'h00000001);
  endtask
  task automatic t_baud();
    // new rate is taken only while both directions are idle
    @(posedge clk_i);
    baud_sel_i <= 3'h3;
    host_u.bit_cyc = SIM_HZ / `SRCE_BAUD_57600;
    repeat (2) @(posedge clk_i);
    wr(16'h0008, 32'h0BAD0057);
    baud_sel_i <= `SRCE_BAUD_SEL_DEFAULT;
    host_u.bit_cyc = SIM_HZ / `SRCE_BAUD_115200;
    repeat (2) @(posedge clk_i);
    rd(16'h0008, 32'h0BAD0057);
  endtask
  task automatic close_out();
    $display("mismatches=%0d check_count=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    t_boot();
    t_map();
    t_rw();
    t_badop();
    t_timeout();
    t_spaces();
    t_restart();
    t_baud();
    close_out();
  end
  // about 160 characters, a few at half rate, near 75000 cycles in all
  initial begin
    repeat (95000) @(posedge clk_i);
    mismatches++;
    close_out();
  end
endmodule // testbench
bind srce_top srce_top_monitor #(.IDX_W(IDX_W)) mon_u (.clk_i(clk_i), .reset_i(reset_i),
  .rx_i(rx_i), .tx_o(tx_o), .baud_sel_i(baud_sel_i), .ready_o(ready_o),
  .ws_index_i(ws_index_i), .ws_data_o(ws_data_o));
